// ===== sdi_pkg.sv
// Constants, types and timing shared by both ends of the stereo DAC serial input link.
// Assumes a single 125 MHz reference clock in each end and no software-visible registers.
//
// What this block does
// - Samples are signed two's complement, MSB first.
// - Data and framing change on bit-clock falling edges.
// - Source gives 16 bit clocks per word.
// - Shared line: channel clock toggles after LSB.
// - Separate lines: word clock falls after LSB.
// - Outputs update 4.5 bit periods after data.
// - Gated shared: channel toggle between LSB end, MSB.
// - Gated separate: word fall between LSB end, MSB.
// - Gated separate: word rise from ninth edge.
// - Channel polarity select flips left channel level.
// - No minimum rate; single word converts.
// - Format select picks shared or separate lines.
// - Separate mode: framing pin delimits words only.

package sdi_pkg;

	// ==========================================================
	// Word format
	localparam int unsigned WORD_BITS     = 16;
	localparam logic [4:0]  BIT_CNT_FIRST = 5'h01;
	localparam logic [4:0]  BIT_CNT_LSB   = 5'h10;
	localparam logic [4:0]  BIT_CNT_OVER  = 5'h11;
	localparam logic [3:0]  BIT_IDX_MSB   = 4'hF;

	typedef logic signed [WORD_BITS-1:0] sdi_sample_t;

	// ==========================================================
	// Link pin positions in the synchroniser vector
	localparam int unsigned PIN_N     = 5;
	localparam int unsigned PIN_FMT   = 0;
	localparam int unsigned PIN_BCK   = 1;
	localparam int unsigned PIN_LEFT  = 2;
	localparam int unsigned PIN_RIGHT = 3;
	localparam int unsigned PIN_FRAME = 4;
	// Synchroniser reset levels: bit clock idles high
	localparam logic [PIN_N-1:0] PIN_IDLE = 5'h02;

	// ==========================================================
	// Timing
	localparam int unsigned REF_PERIOD_NS     = 8;
	localparam int unsigned BCK_MIN_PERIOD_NS = 100;
	localparam int unsigned BCK_MIN_PULSE_NS  = 40;
	localparam int unsigned BCK_HALF_NS       = (BCK_MIN_PERIOD_NS / 2 > BCK_MIN_PULSE_NS) ?
		BCK_MIN_PERIOD_NS / 2 : BCK_MIN_PULSE_NS;
	localparam int unsigned BCK_HALF_CYC      = (BCK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam logic [3:0]  BCK_HALF_LAST     = 4'(BCK_HALF_CYC - 1);

	// Update delay of four and a half measured bit periods
	localparam int unsigned UPD_WHOLE_SHIFT = 2;
	localparam int unsigned PER_W           = 16;
	localparam int unsigned DLY_W           = PER_W + 3;
	localparam logic [PER_W-1:0] PER_MAX    = 16'hFFFF;
	localparam logic [DLY_W-1:0] DLY_FIRE   = 19'h00001;

	// ==========================================================
	// Source sequencing, counted in bit-clock falling edges
	localparam logic [5:0] EDGES_SHARED   = 6'h20;
	localparam logic [5:0] EDGES_SEPARATE = 6'h10;
	localparam logic [5:0] EDGE_RIGHT     = 6'h10;
	localparam logic [5:0] EDGE_WORD_RISE = 6'h08;

	// ==========================================================
	// State machines
	typedef enum logic {
		SRC_IDLE = 1'b0,
		SRC_SEND = 1'b1
	} sdi_src_state_e;

	typedef enum logic {
		UPD_IDLE = 1'b0,
		UPD_WAIT = 1'b1
	} sdi_upd_state_e;

endpackage

// ===== sdi_link_if.sv
// Pin-level link between the sample source and the DAC input.
// Assumes the source end drives every pin; the DAC end only listens.
`timescale 1ns/1ps

interface sdi_link_if;
	// High selects separate left and right lines
	logic format_select;
	logic bit_clock;
	logic left_serial_in;
	// Carries the channel polarity select level in shared-line mode
	logic right_serial_in;
	// Channel clock in shared mode, word framing clock in separate mode
	logic channel_clock;

	modport src (
		output format_select,
		output bit_clock,
		output left_serial_in,
		output right_serial_in,
		output channel_clock
	);

	modport dac (
		input format_select,
		input bit_clock,
		input left_serial_in,
		input right_serial_in,
		input channel_clock
	);
endinterface

// ===== sdi_src_end.sv
// Sample source end: serialises stereo sample pairs onto the link.
// Assumes the user holds valid and both samples until the acknowledge pulse.
`timescale 1ns/1ps

module sdi_src_end (
	// Clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	// Link towards the DAC
	sdi_link_if.src                    link,
	// Mode straps
	input  wire logic                  format_select_i,
	input  wire logic                  gated_clock_i,
	input  wire logic                  channel_polarity_select_i,
	// Sample pair request
	input  wire logic                  sample_valid_i,
	input  wire sdi_pkg::sdi_sample_t  left_sample_i,
	input  wire sdi_pkg::sdi_sample_t  right_sample_i,
	output logic                       sample_ack_o
);
	import sdi_pkg::*;

	sdi_src_state_e state_q, state_d;
	logic [3:0]     div_q, div_d;
	logic [5:0]     edge_q, edge_d;
	logic           bclk_q, bclk_d;
	logic           fmt_q, fmt_d;
	logic           gated_q, gated_d;
	logic           dl_q, dl_d;
	logic           dr_q, dr_d;
	logic           frame_q, frame_d;
	logic           ack_q, ack_d;
	sdi_sample_t    wl_q, wl_d;
	sdi_sample_t    wr_q, wr_d;

	// ==========================================================
	// Sequencer
	always_comb begin
		logic        run;
		logic        tick;
		logic        fall;
		logic        go;
		logic        serial;
		logic [5:0]  total;
		logic [5:0]  e;
		logic [3:0]  idx;
		sdi_sample_t wl;
		sdi_sample_t wr;
		run     = 1'b0;
		tick    = 1'b0;
		fall    = 1'b0;
		go      = 1'b0;
		serial  = ~fmt_q;
		total   = serial ? EDGES_SHARED : EDGES_SEPARATE;
		e       = edge_q;
		idx     = 4'h0;
		wl      = wl_q;
		wr      = wr_q;
		state_d = state_q;
		edge_d  = edge_q;
		dl_d    = dl_q;
		dr_d    = dr_q;
		frame_d = frame_q;
		ack_d   = 1'b0;
		wl_d    = wl_q;
		wr_d    = wr_q;
		fmt_d   = fmt_q;
		gated_d = gated_q;

		// Gated mode runs the bit clock only while a pair is being sent
		run    = ~gated_q | (state_q == SRC_SEND);
		tick   = run & (div_q == BCK_HALF_LAST);
		div_d  = tick | ~run ? 4'h0 : div_q + 4'h1;
		fall   = tick & bclk_q;
		bclk_d = tick ? ~bclk_q : bclk_q;

		if (state_q == SRC_IDLE) begin
			fmt_d   = format_select_i;
			gated_d = gated_clock_i;
			frame_d = serial ? channel_polarity_select_i : 1'b1;
			if (sample_valid_i) begin
				wl_d    = left_sample_i;
				wr_d    = right_sample_i;
				ack_d   = 1'b1;
				edge_d  = 6'h00;
				state_d = SRC_SEND;
			end
		end else if (fall) begin
			if (edge_q == total) begin
				if (!gated_q && sample_valid_i) begin
					// Back to back: next MSB starts on the edge ending this LSB
					wl    = left_sample_i;
					wr    = right_sample_i;
					wl_d  = left_sample_i;
					wr_d  = right_sample_i;
					ack_d = 1'b1;
					e     = 6'h00;
					go    = 1'b1;
				end else begin
					state_d = SRC_IDLE;
					// Gated clock stops high after the LSB period
					if (gated_q) begin
						bclk_d = bclk_q;
					end
				end
			end else begin
				go = 1'b1;
			end
		end

		if (go) begin
			// Every bit boundary and framing change sits on a falling edge
			idx    = BIT_IDX_MSB - e[3:0];
			edge_d = e + 6'h01;
			if (serial) begin
				dl_d = e[4] ? wr[idx] : wl[idx];
				if (e == 6'h00) begin
					frame_d = ~channel_polarity_select_i;
				end else if (e == EDGE_RIGHT) begin
					frame_d = channel_polarity_select_i;
				end
			end else begin
				dl_d = wl[idx];
				dr_d = wr[idx];
				if (e == 6'h00) begin
					frame_d = 1'b0;
				end else if (e == EDGE_WORD_RISE) begin
					frame_d = 1'b1;
				end
			end
		end
		if (serial) begin
			dr_d = channel_polarity_select_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_q <= SRC_IDLE;
			div_q   <= 4'h0;
			edge_q  <= 6'h00;
			bclk_q  <= 1'b1;
			fmt_q   <= 1'b0;
			gated_q <= 1'b0;
			dl_q    <= 1'b0;
			dr_q    <= 1'b0;
			frame_q <= 1'b0;
			ack_q   <= 1'b0;
			wl_q    <= 16'h0000;
			wr_q    <= 16'h0000;
		end else begin
			state_q <= state_d;
			div_q   <= div_d;
			edge_q  <= edge_d;
			bclk_q  <= bclk_d;
			fmt_q   <= fmt_d;
			gated_q <= gated_d;
			dl_q    <= dl_d;
			dr_q    <= dr_d;
			frame_q <= frame_d;
			ack_q   <= ack_d;
			wl_q    <= wl_d;
			wr_q    <= wr_d;
		end
	end

	// ==========================================================
	// Pins
	assign link.format_select   = fmt_q;
	assign link.bit_clock       = bclk_q;
	assign link.left_serial_in  = dl_q;
	assign link.right_serial_in = dr_q;
	assign link.channel_clock   = frame_q;
	assign sample_ack_o         = ack_q;
endmodule

// ===== sdi_dac_end.sv
// DAC input end: deserialises the link into staged left and right samples.
// Assumes link pins are asynchronous to ref_clk_i; each passes two flip-flops first.
`timescale 1ns/1ps

module sdi_dac_end (
	// Clock and reset
	input  wire logic            ref_clk_i,
	input  wire logic            rst_n_i,
	// Link from the sample source
	sdi_link_if.dac              link,
	// Converter side
	output sdi_pkg::sdi_sample_t left_sample_o,
	output sdi_pkg::sdi_sample_t right_sample_o,
	output logic                 sample_update_o,
	// Status
	output logic                 parallel_mode_o,
	output logic                 short_word_o
);
	import sdi_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [PIN_N-1:0] pins;
	logic [PIN_N-1:0] sync1_q, sync1_d;
	logic [PIN_N-1:0] sync2_q, sync2_d;

	assign pins[PIN_FMT]   = link.format_select;
	assign pins[PIN_BCK]   = link.bit_clock;
	assign pins[PIN_LEFT]  = link.left_serial_in;
	assign pins[PIN_RIGHT] = link.right_serial_in;
	assign pins[PIN_FRAME] = link.channel_clock;

	always_comb begin
		sync1_d = pins;
		sync2_d = sync1_q;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sync1_q <= PIN_IDLE;
			sync2_q <= PIN_IDLE;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	// ==========================================================
	// Edge detection and period measurement
	logic             bclk_prev_q, bclk_prev_d;
	logic             frame_prev_q, frame_prev_d;
	logic             start_pend_q, start_pend_d;
	logic [PER_W-1:0] per_cnt_q, per_cnt_d;
	logic [PER_W-1:0] per_q, per_d;
	logic             bck_rise;
	logic             parallel;
	logic             frame_edge;

	assign parallel = sync2_q[PIN_FMT];
	assign bck_rise = sync2_q[PIN_BCK] & ~bclk_prev_q;

	always_comb begin
		bclk_prev_d  = sync2_q[PIN_BCK];
		frame_prev_d = sync2_q[PIN_FRAME];
		// Shared line: any channel clock change; separate: word clock fall only
		if (parallel) begin
			frame_edge = frame_prev_q & ~sync2_q[PIN_FRAME];
		end else begin
			frame_edge = frame_prev_q ^ sync2_q[PIN_FRAME];
		end
		// A framing edge is remembered until the next bit-clock rise; a new edge wins
		start_pend_d = frame_edge | (start_pend_q & ~bck_rise);
		per_cnt_d = per_cnt_q;
		per_d     = per_q;
		if (bck_rise) begin
			per_cnt_d = '0;
			per_d     = (per_cnt_q == PER_MAX) ? PER_MAX : per_cnt_q + 16'h0001;
		end else if (per_cnt_q != PER_MAX) begin
			per_cnt_d = per_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			// Idle level, so leaving reset shows no false bit clock rise
			bclk_prev_q  <= 1'b1;
			frame_prev_q <= 1'b0;
			start_pend_q <= 1'b0;
			per_cnt_q    <= '0;
			per_q        <= '0;
		end else begin
			bclk_prev_q  <= bclk_prev_d;
			frame_prev_q <= frame_prev_d;
			start_pend_q <= start_pend_d;
			per_cnt_q    <= per_cnt_d;
			per_q        <= per_d;
		end
	end

	// ==========================================================
	// Word assembly and staging
	logic [4:0]  cnt_q, cnt_d;
	logic        left_ch_q, left_ch_d;
	logic        short_q, short_d;
	sdi_sample_t shl_q, shl_d;
	sdi_sample_t shr_q, shr_d;
	sdi_sample_t stage_l_q, stage_l_d;
	sdi_sample_t stage_r_q, stage_r_d;
	logic        pair_done;

	always_comb begin
		cnt_d     = cnt_q;
		left_ch_d = left_ch_q;
		shl_d     = shl_q;
		shr_d     = shr_q;
		stage_l_d = stage_l_q;
		stage_r_d = stage_r_q;
		short_d   = 1'b0;
		pair_done = 1'b0;
		if (bck_rise) begin
			// Bits are taken MSB first on the rise, midway between falling edges
			shl_d = {shl_q[WORD_BITS-2:0], sync2_q[PIN_LEFT]};
			shr_d = {shr_q[WORD_BITS-2:0], sync2_q[PIN_RIGHT]};
			if (start_pend_q) begin
				cnt_d     = BIT_CNT_FIRST;
				short_d   = (cnt_q != BIT_CNT_OVER) && (cnt_q != BIT_CNT_LSB);
				// Left when channel clock differs from the polarity select level
				left_ch_d = sync2_q[PIN_FRAME] ^ sync2_q[PIN_RIGHT];
			end else if (cnt_q != BIT_CNT_OVER) begin
				cnt_d = cnt_q + 5'h01;
			end
			// Sixteenth bit after the framing edge closes the word
			if (cnt_d == BIT_CNT_LSB) begin
				if (parallel) begin
					stage_l_d = shl_d;
					stage_r_d = shr_d;
					pair_done = 1'b1;
				end else if (left_ch_d) begin
					stage_l_d = shl_d;
				end else begin
					stage_r_d = shl_d;
					pair_done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			cnt_q     <= BIT_CNT_OVER;
			left_ch_q <= 1'b0;
			short_q   <= 1'b0;
			shl_q     <= 16'h0000;
			shr_q     <= 16'h0000;
			stage_l_q <= 16'h0000;
			stage_r_q <= 16'h0000;
		end else begin
			cnt_q     <= cnt_d;
			left_ch_q <= left_ch_d;
			short_q   <= short_d;
			shl_q     <= shl_d;
			shr_q     <= shr_d;
			stage_l_q <= stage_l_d;
			stage_r_q <= stage_r_d;
		end
	end

	// ==========================================================
	// Output update timer
	sdi_upd_state_e   upd_q, upd_d;
	logic [DLY_W-1:0] dly_q, dly_d;
	sdi_sample_t      out_l_q, out_l_d;
	sdi_sample_t      out_r_q, out_r_d;
	logic             update_q, update_d;

	always_comb begin
		upd_d    = upd_q;
		dly_d    = dly_q;
		out_l_d  = out_l_q;
		out_r_d  = out_r_q;
		update_d = 1'b0;
		if (pair_done) begin
			// Wait four and a half measured bit periods; needs no further bit clock
			dly_d = {3'b000, per_q} << UPD_WHOLE_SHIFT;
			dly_d = dly_d + {4'h0, per_q[PER_W-1:1]};
			upd_d = UPD_WAIT;
		end else if (upd_q == UPD_WAIT) begin
			if (dly_q <= DLY_FIRE) begin
				// Both channels move together so the outputs stay in phase
				out_l_d  = stage_l_q;
				out_r_d  = stage_r_q;
				update_d = 1'b1;
				upd_d    = UPD_IDLE;
			end else begin
				dly_d = dly_q - DLY_FIRE;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			upd_q    <= UPD_IDLE;
			dly_q    <= '0;
			out_l_q  <= 16'h0000;
			out_r_q  <= 16'h0000;
			update_q <= 1'b0;
		end else begin
			upd_q    <= upd_d;
			dly_q    <= dly_d;
			out_l_q  <= out_l_d;
			out_r_q  <= out_r_d;
			update_q <= update_d;
		end
	end

	assign left_sample_o   = out_l_q;
	assign right_sample_o  = out_r_q;
	assign sample_update_o = update_q;
	assign parallel_mode_o = sync2_q[PIN_FMT];
	assign short_word_o    = short_q;
endmodule

// ===== sdi_link_assertions.sv
// Checks on the link pins between the source end and the DAC end.
// Assumes one reference clock and a synchronous active-low reset.
`timescale 1ns/1ps

module sdi_link_assertions (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Link pins
	input wire logic format_select,
	input wire logic bit_clock,
	input wire logic left_serial_in,
	input wire logic right_serial_in,
	input wire logic channel_clock
);
	// ==========
	// Settle tracking
	logic [2:0] up_q;
	logic [2:0] up_d;
	logic [1:0] fs_q;
	logic [1:0] fs_d;
	logic [1:0] rs_q;
	logic [1:0] rs_d;
	logic       calm;

	// Mode and polarity pins steady, reset well past
	always_comb begin
		up_d = {up_q[1:0], 1'b1};
		fs_d = {fs_q[0], format_select};
		rs_d = {rs_q[0], right_serial_in};
		calm = up_q[2] && (fs_q == {2{format_select}})
			&& (format_select || rs_q == {2{right_serial_in}});
	end

	always_ff @(posedge ref_clk_i) begin
		up_q <= rst_n_i ? up_d : 3'h0;
		fs_q <= fs_d;
		rs_q <= rs_d;
	end

	// ==========
	// Properties
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_DATA_ON_BIT_FALL: assert property (
		calm && ($changed(left_serial_in) || (format_select && $changed(right_serial_in)))
		|-> $fell(bit_clock)) else $error("data moved off a bit clock fall");
	AST_FRAME_ON_BIT_FALL: assert property (
		calm && $changed(channel_clock) |-> $fell(bit_clock))
		else $error("framing moved off a bit clock fall");
	AST_BIT_LOW_HALF: assert property (
		$fell(bit_clock) |-> (!bit_clock)[*7] ##1 bit_clock)
		else $error("bit clock low half wrong");
	AST_BIT_HIGH_HALF: assert property (
		$fell(bit_clock) |-> $past(bit_clock, 7)) else $error("bit clock high half short");
	AST_WORD_RISE_WINDOW: assert property (
		calm && format_select && $fell(channel_clock) |-> ##112 $rose(channel_clock))
		else $error("word clock rise misplaced");
	AST_WORD_BIT_COUNT: assert property (
		calm && format_select && $fell(channel_clock) |-> ##210 $fell(bit_clock))
		else $error("separate word not 16 bits");
	AST_CHANNEL_SWAP: assert property (
		calm && !format_select && $changed(channel_clock) && channel_clock != right_serial_in
		|-> ##224 ($changed(channel_clock) && channel_clock == right_serial_in))
		else $error("channel clock swap misplaced");
	AST_LEFT_WORD_BITS: assert property (
		calm && !format_select && $changed(channel_clock) && channel_clock != right_serial_in
		|-> ##210 $fell(bit_clock)) else $error("left word not 16 bits");
endmodule

// ===== tb_top.sv
// End-to-end bench: source end drives the link, DAC end rebuilds the samples.
// Assumes both ends share one 125 MHz clock; the bench is the only stimulus.
`timescale 1ns/1ps

module tb_top;
	import sdi_pkg::*;

	// ==========
	// Signals
	localparam int LIMIT = 9000;
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        fmt = 1'b0;
	logic        gated = 1'b1;
	logic        pol = 1'b0;
	logic        valid = 1'b0;
	sdi_sample_t l_in = 16'h0000;
	sdi_sample_t r_in = 16'h0000;
	sdi_sample_t l_out;
	sdi_sample_t r_out;
	logic        ack;
	logic        upd;
	logic        par;
	logic        short;
	logic        bck_q = 1'b1;
	logic [31:0] lr_q = 32'h0;
	int          mismatches = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          since_rise = 0;

	always #4 ref_clk_i = ~ref_clk_i;

	sdi_link_if sdi_link_if_i ();
	sdi_src_end sdi_src_end_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.link(sdi_link_if_i.src), .format_select_i(fmt), .gated_clock_i(gated),
		.channel_polarity_select_i(pol), .sample_valid_i(valid), .left_sample_i(l_in),
		.right_sample_i(r_in), .sample_ack_o(ack));
	sdi_dac_end sdi_dac_end_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.link(sdi_link_if_i.dac), .left_sample_o(l_out), .right_sample_o(r_out),
		.sample_update_o(upd), .parallel_mode_o(par), .short_word_o(short));
	sdi_link_assertions sdi_link_assertions_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.format_select(sdi_link_if_i.format_select), .bit_clock(sdi_link_if_i.bit_clock),
		.left_serial_in(sdi_link_if_i.left_serial_in),
		.right_serial_in(sdi_link_if_i.right_serial_in),
		.channel_clock(sdi_link_if_i.channel_clock));

	// ==========
	// Reporting
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		if (mismatches == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Cycle count since the last bit clock rise, and the hang limit
	always @(posedge ref_clk_i) begin
		cyc++;
		bck_q <= sdi_link_if_i.bit_clock;
		since_rise <= (sdi_link_if_i.bit_clock && !bck_q) ? 0 : since_rise + 1;
		if (cyc == LIMIT) begin
			mismatches++;
			complete_run;
		end
	end

	always @(negedge ref_clk_i) begin
		if (rst_n_i && upd !== 1'b1 && {l_out, r_out} !== lr_q) check({l_out, r_out}, lr_q);
		if (rst_n_i && short !== 1'b0) check(short, 1'b0);
		lr_q <= {l_out, r_out};
	end

	// ==========
	// Helpers
	task automatic send(input sdi_sample_t l, input sdi_sample_t r, input logic hold);
		int n;
		n = 0;
		l_in = l;
		r_in = r;
		if (valid !== 1'b1) valid = 1'b1;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (ack !== 1'b1 && n < 700);
		check(ack, 1'b1);
		@(negedge ref_clk_i);
		if (!hold) valid = 1'b0;
	endtask

	task automatic grab(input int n, output logic [31:0] a, output logic [31:0] b,
		output logic [31:0] c);
		a = 0;
		b = 0;
		c = 0;
		repeat (n) begin
			@(posedge sdi_link_if_i.bit_clock);
			a = {a[30:0], sdi_link_if_i.left_serial_in};
			b = {b[30:0], sdi_link_if_i.right_serial_in};
			c = {c[30:0], sdi_link_if_i.channel_clock};
		end
	endtask

	task automatic wait_upd(input sdi_sample_t l, input sdi_sample_t r);
		int n;
		n = 0;
		@(negedge ref_clk_i);
		while (upd !== 1'b1 && n < 1200) begin
			@(negedge ref_clk_i);
			n++;
		end
		check({l_out, r_out}, {l, r});
		if (gated) check(since_rise inside {[62:72]}, 1'b1);
	endtask

	// ==========
	// Scenarios
	task automatic t_shared_pol;
		logic [31:0] a, b, c;
		for (int p = 0; p < 2; p++) begin
			fmt = 1'b0;
			gated = 1'b1;
			pol = p[0];
			repeat (4) @(negedge ref_clk_i);
			send(p ? 16'h8000 : 16'h7FFF, p ? 16'h0001 : 16'hFFFF, 1'b0);
			grab(32, a, b, c);
			check(a, p ? 32'h80000001 : 32'h7FFFFFFF);
			check(c, p ? 32'h0000FFFF : 32'hFFFF0000);
			check(b, p ? 32'hFFFFFFFF : 32'h00000000);
			wait_upd(p ? 16'h8000 : 16'h7FFF, p ? 16'h0001 : 16'hFFFF);
			check(par, 1'b0);
		end
	endtask

	task automatic t_separate;
		logic [31:0] a, b, c;
		fmt = 1'b1;
		gated = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		send(16'hA5C3, 16'h5A3C, 1'b0);
		grab(16, a, b, c);
		check({a[15:0], b[15:0]}, 32'hA5C35A3C);
		check(c, 32'h000000FF);
		wait_upd(16'hA5C3, 16'h5A3C);
		check(par, 1'b1);
	endtask

	task automatic t_continuous;
		for (int f = 0; f < 2; f++) begin
			fmt = f[0];
			gated = 1'b0;
			repeat (4) @(negedge ref_clk_i);
			send(16'h1234, 16'hFEDC, 1'b1);
			send(16'h8001, 16'h7FFE, 1'b0);
			wait_upd(16'h1234, 16'hFEDC);
			wait_upd(16'h8001, 16'h7FFE);
		end
		gated = 1'b1;
	endtask

	initial begin
		repeat (10) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		t_shared_pol;
		t_separate;
		t_continuous;
		complete_run;
	end
endmodule
